// *** core/cnt_alarm_core.sv ***
// Counter core with overflow tally, range reload and alarm comparison.
`timescale 1ns/1ps
`default_nettype none
module cnt_alarm_core
   import cnt_alarm_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Configuration and events
   input wire cfg_t cfg,
   input wire logic load,
   input wire logic pulseIn,
   // State out
   output logic [CNT_W-1:0] currentCount,
   output logic signed [CNT_W-1:0] overflowTally,
   output logic alarm
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic signed [CNT_W-1:0] tally;
      logic alarm;
   } core_t;

   core_t st_ff;
   core_t nxt_st;

   always_comb begin
      nxt_st = st_ff;
      if (load) begin
         nxt_st.cnt = cfg.initCount;
      end else if (cfg.ctrl.run && pulseIn) begin
         if (!cfg.ctrl.dirDown) begin
            if (st_ff.cnt == CNT_MAX) begin
               // Wrap past the maximum means the count left the range.
               nxt_st.tally = st_ff.tally + 32'sd1;
               nxt_st.cnt = cfg.initCount;
            end else begin
               nxt_st.cnt = st_ff.cnt + 32'h00000001;
            end
         end else begin
            if (st_ff.cnt == CNT_MIN) begin
               nxt_st.tally = st_ff.tally - 32'sd1;
               nxt_st.cnt = cfg.initCount;
            end else begin
               nxt_st.cnt = st_ff.cnt - 32'h00000001;
            end
         end
      end
      // Compared on the registered count so the alarm is glitch free.
      nxt_st.alarm = cfg.ctrl.alarmEn &&
         ((cfg.ctrl.highEn && st_ff.cnt > cfg.highLimit) ||
          (cfg.ctrl.lowEn && st_ff.cnt < cfg.lowLimit));
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign currentCount = st_ff.cnt;
   assign overflowTally = st_ff.tally;
   assign alarm = st_ff.alarm;

   a_tally_up: assert property (@(posedge clk_sys) disable iff (!resetn)
      (!load && cfg.ctrl.run && pulseIn && !cfg.ctrl.dirDown && st_ff.cnt == CNT_MAX)
      |=> (st_ff.tally == $past(st_ff.tally) + 32'sd1))
      else $error("Tally did not rise on overflow.");
   a_tally_down: assert property (@(posedge clk_sys) disable iff (!resetn)
      (!load && cfg.ctrl.run && pulseIn && cfg.ctrl.dirDown && st_ff.cnt == CNT_MIN)
      |=> (st_ff.tally == $past(st_ff.tally) - 32'sd1))
      else $error("Tally did not fall on underflow.");
   a_range_reload: assert property (@(posedge clk_sys) disable iff (!resetn)
      (!load && cfg.ctrl.run && pulseIn &&
       ((!cfg.ctrl.dirDown && st_ff.cnt == CNT_MAX) ||
        (cfg.ctrl.dirDown && st_ff.cnt == CNT_MIN)))
      |=> (st_ff.cnt == $past(cfg.initCount)))
      else $error("Count not reloaded after leaving range.");
   a_tally_steady: assert property (@(posedge clk_sys) disable iff (!resetn)
      !(cfg.ctrl.run && pulseIn) |=> $stable(st_ff.tally))
      else $error("Tally moved without a pulse.");
   a_alarm_high: assert property (@(posedge clk_sys) disable iff (!resetn)
      (cfg.ctrl.alarmEn && cfg.ctrl.highEn && st_ff.cnt > cfg.highLimit) |=> alarm)
      else $error("High alarm missed.");
   a_alarm_quiet: assert property (@(posedge clk_sys) disable iff (!resetn)
      !cfg.ctrl.alarmEn |=> !alarm)
      else $error("Alarm raised while disabled.");
endmodule
`default_nettype wire

// *** core/cnt_alarm_pkg.sv ***
// Package with register map, field layouts and reset values of the counter alarm channel.
// Functional notes
// - Count passing above the maximum adds one to the overflow tally.
// - Count falling below the minimum subtracts one; the tally may go negative.
// - Leaving the min/max range reloads the initial count and counting resumes.
// - The overflow tally is readable by software.
// - The alarm is routed to a digital output chosen by module, slot, channel.
package cnt_alarm_pkg;
   localparam int unsigned CNT_W = 32;
   localparam logic [CNT_W-1:0] CNT_MIN = 32'h00000000;
   localparam logic [CNT_W-1:0] CNT_MAX = 32'hffffffff;
   localparam int unsigned AW = 6;
   localparam logic [AW-1:0] OFS_CTRL = 6'h00;
   localparam logic [AW-1:0] OFS_INIT = 6'h04;
   localparam logic [AW-1:0] OFS_HIGH = 6'h08;
   localparam logic [AW-1:0] OFS_LOW = 6'h0c;
   localparam logic [AW-1:0] OFS_ROUTE = 6'h10;
   localparam logic [AW-1:0] OFS_COUNT = 6'h14;
   localparam logic [AW-1:0] OFS_TALLY = 6'h18;
   localparam logic [AW-1:0] OFS_STATUS = 6'h1c;
   localparam int unsigned CTRL_RUN = 0;
   localparam int unsigned CTRL_ALARM_EN = 1;
   localparam int unsigned CTRL_HIGH_EN = 2;
   localparam int unsigned CTRL_LOW_EN = 3;
   localparam int unsigned CTRL_DIR_DOWN = 4;
   localparam int unsigned CTRL_LOAD = 5;
   localparam int unsigned DO_W = 4;
   localparam logic [31:0] RST_WORD = 32'h00000000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [3:0] module_sel;
      logic [3:0] slot_sel;
      logic [3:0] chan_sel;
   } route_t;

   typedef struct packed {
      logic run;
      logic alarmEn;
      logic highEn;
      logic lowEn;
      logic dirDown;
   } ctrl_t;

   typedef struct packed {
      logic [CNT_W-1:0] initCount;
      logic [CNT_W-1:0] highLimit;
      logic [CNT_W-1:0] lowLimit;
      route_t route;
      ctrl_t ctrl;
   } cfg_t;
endpackage

// *** core/cnt_alarm_top.sv ***
// AXI4-Lite counter alarm channel with routed digital alarm output.
//
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module cnt_alarm_top
   import cnt_alarm_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Count input pin
   input wire logic countPin,
   // Routed alarm output
   output logic [DO_W-1:0] alarmDo,
   output logic [3:0] alarmModule,
   output logic [3:0] alarmSlot,
   // AXI4-Lite slave
   input wire logic [AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   typedef struct packed {
      cfg_t cfg;
      logic load;
      logic [2:0] pinSync;
      logic awHave;
      logic [AW-1:0] awAddr;
      logic wHave;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bValid;
      logic [1:0] bResp;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
      logic [DO_W-1:0] doOut;
   } top_t;

   top_t st_ff;
   top_t nxt_st;
   logic [CNT_W-1:0] currentCount;
   logic signed [CNT_W-1:0] overflowTally;
   logic alarm;
   logic pulse;
   logic doWrite;
   logic [31:0] wrWord;
   logic [31:0] oldWord;
   logic [31:0] ctrlWord;

   // Two stages synchronise the pin; the third only feeds the edge detector.
   assign pulse = st_ff.pinSync[1] && !st_ff.pinSync[2];

   cnt_alarm_core u_core (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .cfg(st_ff.cfg),
      .load(st_ff.load),
      .pulseIn(pulse),
      .currentCount(currentCount),
      .overflowTally(overflowTally),
      .alarm(alarm)
   );

   assign ctrlWord = {26'h0000000, 1'b0, st_ff.cfg.ctrl.dirDown, st_ff.cfg.ctrl.lowEn,
      st_ff.cfg.ctrl.highEn, st_ff.cfg.ctrl.alarmEn, st_ff.cfg.ctrl.run};
   assign doWrite = st_ff.awHave && st_ff.wHave && !st_ff.bValid;

   always_comb begin
      oldWord = 32'h00000000;
      unique case (st_ff.awAddr)
         OFS_CTRL: oldWord = ctrlWord;
         OFS_INIT: oldWord = st_ff.cfg.initCount;
         OFS_HIGH: oldWord = st_ff.cfg.highLimit;
         OFS_LOW: oldWord = st_ff.cfg.lowLimit;
         OFS_ROUTE: oldWord = {20'h00000, st_ff.cfg.route};
         default: oldWord = 32'h00000000;
      endcase
      for (int i = 0; i < 4; i++) begin
         wrWord[i*8 +: 8] = st_ff.wStrb[i] ? st_ff.wData[i*8 +: 8] : oldWord[i*8 +: 8];
      end
   end

   always_comb begin
      nxt_st = st_ff;
      nxt_st.load = 1'b0;
      nxt_st.pinSync = {st_ff.pinSync[1:0], countPin};
      if (s_axi_awvalid && !st_ff.awHave) begin
         nxt_st.awHave = 1'b1;
         nxt_st.awAddr = {s_axi_awaddr[AW-1:2], 2'b00};
      end
      if (s_axi_wvalid && !st_ff.wHave) begin
         nxt_st.wHave = 1'b1;
         nxt_st.wData = s_axi_wdata;
         nxt_st.wStrb = s_axi_wstrb;
      end
      if (doWrite) begin
         nxt_st.awHave = 1'b0;
         nxt_st.wHave = 1'b0;
         nxt_st.bValid = 1'b1;
         nxt_st.bResp = RESP_OKAY;
         unique case (st_ff.awAddr)
            OFS_CTRL: begin
               nxt_st.cfg.ctrl.run = wrWord[CTRL_RUN];
               // Host must have set initial count and a limit before this bit.
               nxt_st.cfg.ctrl.alarmEn = wrWord[CTRL_ALARM_EN];
               nxt_st.cfg.ctrl.highEn = wrWord[CTRL_HIGH_EN];
               nxt_st.cfg.ctrl.lowEn = wrWord[CTRL_LOW_EN];
               nxt_st.cfg.ctrl.dirDown = wrWord[CTRL_DIR_DOWN];
               nxt_st.load = wrWord[CTRL_LOAD];
            end
            OFS_INIT: nxt_st.cfg.initCount = wrWord;
            OFS_HIGH: nxt_st.cfg.highLimit = wrWord;
            OFS_LOW: nxt_st.cfg.lowLimit = wrWord;
            OFS_ROUTE: nxt_st.cfg.route = wrWord[11:0];
            OFS_COUNT, OFS_TALLY, OFS_STATUS: nxt_st.bResp = RESP_OKAY;
            default: nxt_st.bResp = RESP_SLVERR;
         endcase
      end
      if (st_ff.bValid && s_axi_bready) begin
         nxt_st.bValid = 1'b0;
      end
      if (s_axi_arvalid && !st_ff.rValid) begin
         nxt_st.rValid = 1'b1;
         nxt_st.rResp = RESP_OKAY;
         unique case ({s_axi_araddr[AW-1:2], 2'b00})
            OFS_CTRL: nxt_st.rData = ctrlWord;
            OFS_INIT: nxt_st.rData = st_ff.cfg.initCount;
            OFS_HIGH: nxt_st.rData = st_ff.cfg.highLimit;
            OFS_LOW: nxt_st.rData = st_ff.cfg.lowLimit;
            OFS_ROUTE: nxt_st.rData = {20'h00000, st_ff.cfg.route};
            OFS_COUNT: nxt_st.rData = currentCount;
            OFS_TALLY: nxt_st.rData = overflowTally;
            OFS_STATUS: nxt_st.rData = {31'h00000000, alarm};
            default: begin
               nxt_st.rData = 32'h00000000;
               nxt_st.rResp = RESP_SLVERR;
            end
         endcase
      end else if (st_ff.rValid && s_axi_rready) begin
         nxt_st.rValid = 1'b0;
      end
      // Only the selected output line carries the alarm; the others stay low.
      for (int i = 0; i < DO_W; i++) begin
         nxt_st.doOut[i] = alarm && (st_ff.cfg.route.chan_sel == 4'(i));
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign s_axi_awready = !st_ff.awHave;
   assign s_axi_wready = !st_ff.wHave;
   assign s_axi_bvalid = st_ff.bValid;
   assign s_axi_bresp = st_ff.bResp;
   assign s_axi_arready = !st_ff.rValid;
   assign s_axi_rvalid = st_ff.rValid;
   assign s_axi_rdata = st_ff.rData;
   assign s_axi_rresp = st_ff.rResp;
   assign alarmDo = st_ff.doOut;
   assign alarmModule = st_ff.cfg.route.module_sel;
   assign alarmSlot = st_ff.cfg.route.slot_sel;

   a_do_route: assert property (@(posedge clk_sys) disable iff (!resetn)
      (alarm && st_ff.cfg.route.chan_sel < 4'(DO_W)) |=> (alarmDo != '0))
      else $error("Alarm not routed to output.");
   a_do_idle: assert property (@(posedge clk_sys) disable iff (!resetn)
      !alarm |=> (alarmDo == '0))
      else $error("Output set without alarm.");
   a_load_init: assert property (@(posedge clk_sys) disable iff (!resetn)
      st_ff.load |=> (currentCount == $past(st_ff.cfg.initCount)))
      else $error("Initial count not loaded.");
endmodule
`default_nettype wire

// *** test/count_pulse_source.sv ***
// Partner model: external pulse source that drives the count pin.
`timescale 1ns/1ps
`default_nettype none
module count_pulse_source (
   // Clock
   input wire logic clk_sys,
   // Request
   input wire logic start,
   input wire logic [7:0] numPulses,
   // Pin side
   output logic countPin,
   output logic busy
);
   logic [9:0] phase_ff = 10'h000;
   // Two cycles high and two low, so the pin synchroniser sees every edge.
   assign countPin = (phase_ff != 10'h000) && phase_ff[1];
   assign busy = (phase_ff != 10'h000) || start;
   always @(posedge clk_sys) begin
      if (start) begin
         phase_ff <= {numPulses, 2'h0};
      end else if (phase_ff != 10'h000) begin
         phase_ff <= phase_ff - 10'h001;
      end
   end
endmodule
`default_nettype wire

// *** test/counter_alarm_overflow_totalizer_test.sv ***
// Self-checking bench for the counter alarm channel.
`timescale 1ns/1ps
`default_nettype none
module counter_alarm_overflow_totalizer_test
   import cnt_alarm_pkg::*;
;
   logic clk_sys = 1'h0;
   logic resetn = 1'h0;
   logic start = 1'h0;
   logic [7:0] numPulses = 8'h00;
   wire countPin;
   wire pulseBusy;
   logic [DO_W-1:0] alarmDo;
   logic [3:0] alarmModule, alarmSlot;
   logic [AW-1:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
   // Both response readies stay high; that is legal and avoids re-driving them per transfer.
   logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   int fails = 0;
   int numChecks = 0;
   always #2 clk_sys = ~clk_sys;
   cnt_alarm_top dut (.clk_sys, .resetn, .countPin, .alarmDo, .alarmModule, .alarmSlot,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   count_pulse_source pulser (.clk_sys, .start, .numPulses, .countPin, .busy(pulseBusy));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      numChecks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      if (fails == 0 && numChecks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic axi_write(input logic [AW-1:0] a, input logic [31:0] d, output logic [1:0] r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      do begin
         @(posedge clk_sys);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
   endtask
   task automatic axi_read(input logic [AW-1:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      do begin
         @(posedge clk_sys);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask
   task automatic do_reset();
      resetn <= 1'h0;
      repeat (10) @(posedge clk_sys);
      resetn <= 1'h1;
   endtask
   function automatic void step(input logic dn, input logic [31:0] ini,
      inout logic [31:0] c, inout logic [31:0] t);
      if (!dn && c == CNT_MAX) begin
         c = ini;
         t = t + 32'h1;
      end else if (dn && c == CNT_MIN) begin
         c = ini;
         t = t - 32'h1;
      end else begin
         c = dn ? c - 32'h1 : c + 32'h1;
      end
   endfunction
   function automatic logic [63:0] total(input logic [31:0] ini, input logic [31:0] cur,
      input logic [31:0] t, input logic dn);
      logic [63:0] span, mag;
      span = dn ? {32'h0, ini} + 64'h1 : {32'h0, CNT_MAX - ini} + 64'h1;
      mag = t[31] ? {32'h0, -t} : {32'h0, t};
      return span * mag + {32'h0, (cur > ini) ? cur - ini : ini - cur};
   endfunction
   initial begin
      logic [31:0] ini, c, t, hi, lo, d, cRd, tRd;
      logic [63:0] tot;
      logic [11:0] rt;
      logic [1:0] r;
      logic dn, al, hEn, lEn;
      int n;
      void'($urandom(32'ha6303d7f));
      do_reset();
      for (int i = 0; i < 8; i++) begin
         axi_read(AW'(i * 4), d, r);
         check(d, RST_WORD);
      end
      axi_read(6'h24, d, r);
      check({30'h0, r}, {30'h0, RESP_SLVERR});
      check({28'h0, alarmDo}, 32'h0);
      // Partial strobes keep the untouched lanes, and an unmapped write is refused.
      s_axi_wstrb <= 4'h3;
      axi_write(OFS_INIT, 32'h89abcdef, r);
      check({30'h0, r}, {30'h0, RESP_OKAY});
      s_axi_wstrb <= 4'hf;
      axi_read(OFS_INIT, d, r);
      check(d, 32'h0000cdef);
      axi_write(6'h24, 32'h00000001, r);
      check({30'h0, r}, {30'h0, RESP_SLVERR});
      for (int k = 0; k < 6; k++) begin
         dn = k[0];
         // Each limit is enabled at random, but bit 1 of k forces one of them on: high when set, low when clear.
         hEn = k[1] | 1'($urandom);
         lEn = !k[1] | 1'($urandom);
         do_reset();
         ini = dn ? $urandom % 6 : CNT_MAX - $urandom % 6;
         hi = dn ? 32'hfffffff0 : CNT_MAX - $urandom % 8;
         lo = dn ? $urandom % 6 : 32'h0;
         rt = {4'($urandom), 4'($urandom), 2'h0, 2'($urandom)};
         axi_write(OFS_INIT, ini, r);
         axi_write(OFS_HIGH, hi, r);
         axi_write(OFS_LOW, lo, r);
         axi_write(OFS_ROUTE, {20'h0, rt}, r);
         // A stray write to the read-only count must not disturb counting.
         axi_write(OFS_COUNT, $urandom, r);
         check({30'h0, r}, {30'h0, RESP_OKAY});
         axi_write(OFS_CTRL, 32'h23 | {27'h0, dn, lEn, hEn, 2'h0}, r);
         check({30'h0, r}, {30'h0, RESP_OKAY});
         c = ini;
         t = 32'h0;
         n = 4 + $urandom % 12;
         numPulses <= 8'(n);
         start <= 1'h1;
         @(posedge clk_sys);
         start <= 1'h0;
         while (pulseBusy) @(posedge clk_sys);
         repeat (8) @(posedge clk_sys);
         repeat (n) step(dn, ini, c, t);
         axi_read(OFS_COUNT, cRd, r);
         check(cRd, c);
         axi_read(OFS_TALLY, tRd, r);
         check(tRd, t);
         tot = total(ini, cRd, tRd, dn);
         check(tot[31:0], 32'(n));
         al = (hEn && c > hi) || (lEn && c < lo);
         axi_read(OFS_STATUS, d, r);
         check(d, {31'h0, al});
         check({28'h0, alarmDo}, al ? 32'h1 << rt[1:0] : 32'h0);
         check({24'h0, alarmModule, alarmSlot}, {24'h0, rt[11:4]});
      end
      report_and_stop();
   end
   // Whole run needs under seven hundred cycles; this leaves a wide margin.
   initial begin
      repeat (20000) @(posedge clk_sys);
      fails++;
      report_and_stop();
   end
endmodule
`default_nettype wire
